// [hdl/ier_interrupt_enable_request_regs.v]
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ier_regs.vh"

// Functional notes
// - enable bit 7 gates direct-transfer requests; resets to 0
// - enable bit 6 gates converter-done requests; resets to 0
// - enable bit 4 gates serial channel 1 done requests; resets to 0
// - bits 3..0 of enable-b and flags-b read 0, ignore writes
// - bit 5 of enable-b, flags-a, flags-b reads 0, ignores writes
// - bit 4 of flags-a always reads 1, never written
// - enable-b register is 8 bits, resets to 00
// - group-b pin enable: bit n enables pin n requests
// - group-b pin enable is PIN_B_COUNT bits (8 by default), resets to 00
// - flags-a bit 7 sets on timer B1 wrap FF to 00
// - flags-a bit 6 sets on timer A wrap FF to 00
// - flags-a bits 3..0 set on selected group-a pin edge
// - flags clear only by writing 0; writing 1 never sets
// - acceptance does not clear flags; software must write 0
// - flags-a is 8 bits, resets to 10
// - flags-b bit 7 sets on sleep-triggered direct transfer
// - flags-b bit 6 sets on conversion completion
// - flags-b bit 4 sets on serial channel 1 transfer done
// - flags-b is 8 bits, resets to 00
// - request leaves only when enabled; core mask gates acceptance
module ier_interrupt_enable_request_regs #(
    parameter PIN_B_COUNT = 8
) (
    // clock and reset
    input  wire                   core_clk,
    input  wire                   reset,
    // register port
    input  wire [3:0]             reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_write,
    input  wire                   reg_read,
    output reg  [7:0]             reg_rdata,
    // event sources, one-cycle pulses, and the group-a pin edge select pin_a_irq_mode
    input  wire                   timer_b1_wrap,
    input  wire                   timer_a_wrap,
    input  wire [3:0]             ext_edge_pin_a_event,
    input  wire [3:0]             pin_a_irq_mode,
    input  wire                   direct_xfer_event,
    input  wire                   conv_done_event,
    input  wire                   serial1_done_event,
    // group-b pin requests from the edge detectors
    input  wire [PIN_B_COUNT-1:0] ext_edge_pin_b_pending,
    // enables for the sources outside this block
    input  wire [5:0]             group_a_enable,
    // core mask bit of the condition code register
    input  wire                   core_mask,
    // requests toward priority logic
    output reg  [9:0]             pending,
    output reg  [PIN_B_COUNT-1:0] pin_b_pending,
    output reg                    irq_accept_ok
);

    // enable and flag storage
    reg  [7:0]             peripheral_irq_enable_b;
    reg  [PIN_B_COUNT-1:0] pin_group_b_enable;
    reg  [7:0]             request_flags_a;
    reg  [7:0]             request_flags_b;

    // decoded writes
    wire wr_en_b   = reg_write && (reg_addr == `IER_OFF_PERIPH_EN_B);
    wire wr_pin_b  = reg_write && (reg_addr == `IER_OFF_PIN_B_EN);
    wire wr_flag_a = reg_write && (reg_addr == `IER_OFF_REQ_FLAGS_A);
    wire wr_flag_b = reg_write && (reg_addr == `IER_OFF_REQ_FLAGS_B);

    // hardware set vectors
    wire [7:0] set_a;
    wire [7:0] set_b;
    assign set_a = {timer_b1_wrap, timer_a_wrap, 2'b00,
                    ext_edge_pin_a_event & pin_a_irq_mode};
    assign set_b = {direct_xfer_event, conv_done_event, 1'b0,
                    serial1_done_event, 4'h0};

    // next flag value: written 0 clears, written 1 keeps, set wins over clear
    function [7:0] flag_next;
        input [7:0] cur;
        input [7:0] set;
        input       wr;
        input [7:0] wdata;
        input [7:0] mask;
        begin
            if (wr)
                flag_next = ((cur & wdata) | set) & mask;
            else
                flag_next = (cur | set) & mask;
        end
    endfunction

    wire [7:0] next_flags_a;
    wire [7:0] next_flags_b;
    assign next_flags_a = flag_next(request_flags_a, set_a, wr_flag_a, reg_wdata,
                                    `IER_MASK_REQ_FLAGS_A) | `IER_RST_REQ_FLAGS_A;
    assign next_flags_b = flag_next(request_flags_b, set_b, wr_flag_b, reg_wdata,
                                    `IER_MASK_REQ_FLAGS_B);

    // register storage; reserved bits held at 0 by masks, flags-a bit 4 held at 1 by the reset-value OR
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            peripheral_irq_enable_b <= `IER_RST_PERIPH_EN_B;
            pin_group_b_enable      <= {PIN_B_COUNT{1'b0}};
            request_flags_a         <= `IER_RST_REQ_FLAGS_A;
            request_flags_b         <= `IER_RST_REQ_FLAGS_B;
        end else begin
            if (wr_en_b)
                peripheral_irq_enable_b <= reg_wdata & `IER_MASK_PERIPH_EN_B;
            if (wr_pin_b)
                pin_group_b_enable <= reg_wdata[PIN_B_COUNT-1:0];
            request_flags_a <= next_flags_a;
            request_flags_b <= next_flags_b;
        end
    end

    // gated requests, registered so outputs come from flip-flops
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pending       <= 10'h000;
            pin_b_pending <= {PIN_B_COUNT{1'b0}};
            irq_accept_ok <= 1'b0;
        end else begin
            pending[0] <= next_flags_a[`IER_BIT_TIMER_B1] & group_a_enable[5];
            pending[1] <= next_flags_a[`IER_BIT_TIMER_A] & group_a_enable[4];
            pending[5:2] <= next_flags_a[3:0] & group_a_enable[3:0];
            pending[6] <= next_flags_b[`IER_BIT_DIRECT_XFER] &
                          peripheral_irq_enable_b[`IER_BIT_DIRECT_XFER];
            pending[7] <= next_flags_b[`IER_BIT_CONV_DONE] &
                          peripheral_irq_enable_b[`IER_BIT_CONV_DONE];
            pending[8] <= next_flags_b[`IER_BIT_SERIAL1] &
                          peripheral_irq_enable_b[`IER_BIT_SERIAL1];
            pending[9] <= 1'b0;
            pin_b_pending <= ext_edge_pin_b_pending & pin_group_b_enable;
            // acceptance allowed only with something pending and mask clear
            irq_accept_ok <= ~core_mask &
                             ((|pending[8:0]) | (|pin_b_pending));
        end
    end

    // read data one cycle after the strobe, zero otherwise and when unmapped
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `IER_OFF_PERIPH_EN_B: reg_rdata <= peripheral_irq_enable_b;
                `IER_OFF_PIN_B_EN:    reg_rdata <= pin_group_b_enable;
                `IER_OFF_REQ_FLAGS_A: reg_rdata <= request_flags_a;
                `IER_OFF_REQ_FLAGS_B: reg_rdata <= request_flags_b;
                `IER_OFF_PENDING:     reg_rdata <= pending[7:0];
                default:              reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // ier_interrupt_enable_request_regs

// [hdl/ier_regs.vh]
`ifndef IER_REGS_VH
`define IER_REGS_VH

// register offsets on the plain register port
`define IER_OFF_PERIPH_EN_B     4'h0
`define IER_OFF_PIN_B_EN        4'h1
`define IER_OFF_REQ_FLAGS_A     4'h2
`define IER_OFF_REQ_FLAGS_B     4'h3
`define IER_OFF_PENDING         4'h4

// peripheral_irq_enable_b fields
`define IER_BIT_DIRECT_XFER     7
`define IER_BIT_CONV_DONE       6
`define IER_BIT_SERIAL1         4

// request_flags_a fields
`define IER_BIT_TIMER_B1        7
`define IER_BIT_TIMER_A         6
`define IER_BIT_FIXED_ONE       4

// writable masks: reserved bits are outside them
`define IER_MASK_PERIPH_EN_B    8'hD0
`define IER_MASK_REQ_FLAGS_A    8'hCF
`define IER_MASK_REQ_FLAGS_B    8'hD0

// reset values
`define IER_RST_PERIPH_EN_B     8'h00
`define IER_RST_PIN_B_EN        8'h00
`define IER_RST_REQ_FLAGS_A     8'h10
`define IER_RST_REQ_FLAGS_B     8'h00

`endif

// [verification/ier_chk.sv]
`timescale 1ns/1ps
module ier_chk #(parameter PIN_B_COUNT = 8) (
    // clock, reset and register port
    input wire logic                   core_clk,
    input wire logic                   reset,
    input wire logic [3:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_write,
    input wire logic                   reg_read,
    input wire logic [7:0]             reg_rdata,
    // sources, masks and requests
    input wire logic                   timer_b1_wrap,
    input wire logic                   timer_a_wrap,
    input wire logic [5:0]             group_a_enable,
    input wire logic [PIN_B_COUNT-1:0] ext_edge_pin_b_pending,
    input wire logic                   core_mask,
    input wire logic [9:0]             pending,
    input wire logic [PIN_B_COUNT-1:0] pin_b_pending,
    input wire logic                   irq_accept_ok
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // reserved bits seen through the read slot
    fixed_bits_a: assert property (reg_read && reg_addr == 4'h2 |=> reg_rdata[5:4] == 2'b01)
        else $error("flags_a fixed bits wrong");
    rsvd_zero_a: assert property (reg_read && (reg_addr == 4'h0 || reg_addr == 4'h3) |=>
        reg_rdata[5] == 1'b0 && reg_rdata[3:0] == 4'h0) else $error("reserved bits not zero");
    // enabled wraps raise the request on the next edge
    tb1_set_a: assert property (timer_b1_wrap && group_a_enable[5] |=> pending[0])
        else $error("timer b1 request missing");
    ta_set_a: assert property (timer_a_wrap && group_a_enable[4] |=> pending[1])
        else $error("timer a request missing");
    // only a zero write drops a flag; acceptance does not
    tb1_hold_a: assert property (pending[0] && group_a_enable[5] &&
        !(reg_write && reg_addr == 4'h2 && !reg_wdata[7]) |=> pending[0]) else $error("flag lost");
    gate_off_a: assert property (!group_a_enable[4] |=> !pending[1]) else $error("disabled request");
    pin_b_gate_a: assert property ((pin_b_pending & ~$past(ext_edge_pin_b_pending)) == '0)
        else $error("pin b request without source");
    accept_mask_a: assert property (irq_accept_ok |-> !$past(core_mask))
        else $error("accepted while masked");
endmodule // ier_chk

bind ier_interrupt_enable_request_regs ier_chk #(.PIN_B_COUNT(PIN_B_COUNT)) chk_u (.*);

// [verification/ier_src.sv]
`timescale 1ns/1ps
module ier_src (
    // clock
    input  wire logic       core_clk,
    // requests from the bench, pulses toward the block
    input  wire logic [8:0] fire,
    output logic      [8:0] evt
);
    // registered so each event changes on a clock edge, one cycle after fire and lasting as long as fire is held
    always @(posedge core_clk) begin
        evt <= fire;
    end
endmodule // ier_src

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
    logic       core_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, core_mask = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, pin_b_in = 8'h00, reg_rdata, pin_b_pending;
    logic [8:0] fire = 9'h000, evt;
    logic [9:0] pending;
    logic       irq_accept_ok;
    logic [5:0] group_a_en = 6'h3F;
    int         error_cnt = 0, compares = 0;
    `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
        $display("[ERR] %s expected %h seen %h", nm, e, g); end end
    always #12.5 core_clk = ~core_clk;
    ier_interrupt_enable_request_regs dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .timer_b1_wrap(evt[8]), .timer_a_wrap(evt[7]), .ext_edge_pin_a_event(evt[6:3]),
        .pin_a_irq_mode(4'h6), .direct_xfer_event(evt[2]), .conv_done_event(evt[1]),
        .serial1_done_event(evt[0]), .ext_edge_pin_b_pending(pin_b_in), .group_a_enable(group_a_en),
        .core_mask(core_mask), .pending(pending), .pin_b_pending(pin_b_pending), .irq_accept_ok(irq_accept_ok));
    ier_src src_u (.core_clk(core_clk), .fire(fire), .evt(evt));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    // data is looked at only in the one cycle it stands
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 `CHK(nm, e, reg_rdata)
    endtask
    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        rd(4'h0, 8'h00, "enable_b reset");
        rd(4'h1, 8'h00, "pin_b_en reset");
        rd(4'h2, 8'h10, "flags_a reset");
        rd(4'h3, 8'h00, "flags_b reset");
        wr(4'h0, 8'hFF);
        rd(4'h0, 8'hD0, "enable_b mask");
        wr(4'h1, 8'hFF);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h10, "flags_a one write");
        rd(4'hF, 8'h00, "unmapped");
        $display("register test done");
        @(posedge core_clk) fire <= 9'h1FF;
        @(posedge core_clk) fire <= 9'h000;
        repeat (3) @(posedge core_clk);
        rd(4'h2, 8'hD6, "flags_a set");
        rd(4'h3, 8'hD0, "flags_b set");
        rd(4'h4, 8'hDB, "pending");
        `CHK("accept masked", 1'b0, irq_accept_ok)
        @(posedge core_clk);
        core_mask <= 1'b0;
        pin_b_in <= 8'hA5;
        repeat (3) @(posedge core_clk);
        #1 `CHK("accept open", 1'b1, irq_accept_ok)
        `CHK("pin_b pending", 8'hA5, pin_b_pending)
        rd(4'h2, 8'hD6, "flags kept");
        wr(4'h1, 8'h0F);
        wr(4'h2, 8'h7F);
        wr(4'h3, 8'h00);
        rd(4'h2, 8'h56, "flags_a clear");
        rd(4'h3, 8'h00, "flags_b clear");
        `CHK("pin_b gated", 8'h05, pin_b_pending)
        // timer b1 wrap lands on the same edge as a write clearing its flag
        @(posedge core_clk);
        fire <= 9'h100;
        reg_addr <= 4'h2;
        reg_wdata <= 8'h7F;
        @(posedge core_clk);
        fire <= 9'h000;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        rd(4'h2, 8'hD6, "set beats clear");
        // timer a enable dropped outside: its flag stays, its request does not
        @(posedge core_clk);
        group_a_en <= 6'h2F;
        repeat (2) @(posedge core_clk);
        rd(4'h4, 8'h19, "pending gated");
        $display("event test done");
        report_and_stop();
    end
endmodule // tb
